//--- src/ext_mem_pkg.sv
// Constants, field layout and carriers for the external memory port.
// Assumes a single 250 MHz clock shared by the bus slave and the engine.
package ext_mem_pkg;

  // ------------------------------------------------------------
  // Clock and pin timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int T_STROBE_NS = 45;
  localparam int T_RECOVER_NS = 39;
  localparam int T_CAS_RAS_NS = 18;
  localparam int T_RF_HOLD_NS = 110;
  localparam int T_PRECHARGE_NS = 70;

  // Least times round up, never below one cycle
  function automatic int min_cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction : min_cyc

  localparam logic [7:0] STROBE_CYC = 8'(min_cyc(T_STROBE_NS));
  localparam logic [7:0] RECOVER_CYC = 8'(min_cyc(T_RECOVER_NS));
  localparam logic [7:0] CAS_RAS_CYC = 8'(min_cyc(T_CAS_RAS_NS));
  localparam logic [7:0] RF_HOLD_CYC = 8'(min_cyc(T_RF_HOLD_NS));
  localparam logic [7:0] PRECHARGE_CYC = 8'(min_cyc(T_PRECHARGE_NS));
  localparam logic [7:0] STROBE_STEP = 8'h04;
  localparam int REF_BASE_CYC = 256;

  // ------------------------------------------------------------
  // Register map (byte offsets) and fields
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_WDATA = 8'h08;
  localparam logic [7:0] OFF_RDATA = 8'h0C;
  localparam logic [7:0] OFF_ROFS0 = 8'h10;
  localparam logic [7:0] OFF_ROFS1 = 8'h14;
  localparam logic [7:0] OFF_WADDR = 8'h18;

  localparam int CTRL_W = 10;
  localparam int CTRL_SRAM = 0;
  localparam int CTRL_W24 = 1;
  localparam int CTRL_RDLOAD = 2;
  localparam int CTRL_RDIV = 3;
  localparam int CTRL_STIM = 6;
  localparam int CTRL_OFSSEL = 8;
  localparam int CTRL_IE = 9;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h000;

  localparam int STAT_BUSY = 0;
  localparam int STAT_RDV = 1;
  localparam int STAT_FULL = 2;

  // ------------------------------------------------------------
  // Widths and unit counts
  // ------------------------------------------------------------
  localparam int ADDR_W = 18;
  localparam int WORD_W = 24;
  localparam int DQ_W = 4;
  localparam int AD_W = 8;
  localparam int MA_W = 9;
  localparam int SRAM_A_W = 14;
  localparam logic [2:0] UNITS_DRAM16 = 3'h4;
  localparam logic [2:0] UNITS_DRAM24 = 3'h6;
  localparam logic [2:0] UNITS_SRAM16 = 3'h2;
  localparam logic [2:0] UNITS_SRAM24 = 3'h3;

  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] data;
  } cmd_t;

  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [MA_W-1:0] ma;
    logic [DQ_W-1:0] dq_o;
    logic dq_oe_n;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic ale;
    logic [AD_W-1:0] ad_o;
    logic ad_oe_n;
  } mem_pins_t;

  localparam mem_pins_t PINS_IDLE = '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
    ma: 9'h000, dq_o: 4'h0, dq_oe_n: 1'b1, cs_n: 1'b1, rd_n: 1'b1,
    wr_n: 1'b1, ale: 1'b0, ad_o: 8'h00, ad_oe_n: 1'b1};

  typedef enum logic [3:0] {
    ST_IDLE, ST_START, ST_ROW, ST_SA_HI, ST_SA_LO, ST_STB, ST_GAP,
    ST_RF_CAS, ST_RF_RAS, ST_RF_PRE
  } eng_state_t;

endpackage : ext_mem_pkg

//--- src/cmd_buffer.sv
// Small FIFO of flip-flops with valid/ready on both sides.
// Assumes the consumer may hold out_ready low for any time.
`timescale 1ns/100ps
module cmd_buffer #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input logic clk,
  input logic reset,
  // Fill side
  input logic in_valid,
  output logic in_ready,
  input logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [W-1:0] mem_r [DEPTH];
  logic [PW-1:0] wp_r;
  logic [PW-1:0] rp_r;
  logic [PW:0] cnt_r;
  logic push;
  logic pop;

  assign in_ready = (cnt_r != (PW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == PW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == PW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

endmodule : cmd_buffer

//--- src/refresh_tick.sv
// Refresh interval divider: one-cycle tick every BASE << sel cycles.
// Assumes sel may change at any time; the new period applies at once, with an early wrap if the count is already past it.
`timescale 1ns/100ps
module refresh_tick #(
  parameter int BASE = 256
) (
  // Clock and reset
  input logic clk,
  input logic reset,
  // Control
  input logic [2:0] sel,
  output logic tick
);
  logic [23:0] cnt_r;
  logic [23:0] period;

  assign period = 24'(BASE) << sel;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_r <= '0;
      tick <= 1'b0;
    end else if (cnt_r >= period - 24'h000001) begin
      cnt_r <= '0;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 24'h000001;
      tick <= 1'b0;
    end
  end

endmodule : refresh_tick

//--- src/external_memory_port.sv
// External memory port: AHB-Lite register slave plus DRAM/SRAM engine.
// Assumes one upstream bus shared by both processing cores, one clock.
`timescale 1ns/100ps

module external_memory_port
  import ext_mem_pkg::*;
#(
  parameter int REF_BASE = REF_BASE_CYC
) (
  // Clock and reset
  input logic clk,
  input logic reset,
  // AHB-Lite slave
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic [31:0] hwdata,
  input logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Memory pins
  output mem_pins_t pins,
  input logic [DQ_W-1:0] dq_i,
  input logic [AD_W-1:0] ad_i,
  // Read-complete interrupt
  output logic rd_irq
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic ph_r;
  logic ph_wr_r;
  logic [7:0] ph_addr_r;
  logic hreadyout_r;
  logic [31:0] hrdata_r;
  logic [CTRL_W-1:0] ctrl_r;
  logic [ADDR_W-1:0] rofs_r [2];
  logic [ADDR_W-1:0] waddr_r;
  logic [WORD_W-1:0] rdata_r;
  logic rdv_r;
  logic rd_irq_r;
  logic ref_pend_r;
  mem_pins_t pins_r;
  eng_state_t st_r;
  logic [7:0] tmr_r;
  logic [2:0] idx_r;
  logic cmd_wr_r;
  logic [ADDR_W-1:0] cmd_addr_r;
  logic [WORD_W-1:0] wsh_r;
  logic [WORD_W-1:0] rsh_r;
  logic rd_done;
  logic push_req;
  logic stall;
  logic commit;
  cmd_t push_cmd;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_pop;
  cmd_t buf_out;
  logic ref_tick;
  logic [31:0] rd_mux;
  logic is_sram;
  logic is_w24;
  logic [2:0] units;
  logic [ADDR_W-1:0] ua;
  logic [7:0] stb_cyc;
  logic [7:0] gap_cyc;
  logic [AD_W-1:0] wr_unit;
  logic [ADDR_W-1:0] sel_ofs;

  assign is_sram = ctrl_r[CTRL_SRAM];
  assign is_w24 = ctrl_r[CTRL_W24];
  assign sel_ofs = rofs_r[ctrl_r[CTRL_OFSSEL]];

  // ------------------------------------------------------------
  // AHB-Lite data phase
  // ------------------------------------------------------------
  // Every access takes one wait state; pushes that find the buffer
  // full keep hreadyout low, so back-pressure reaches the master.
  always_comb begin
    push_req = 1'b0;
    push_cmd = '0;
    if (ph_r && ph_wr_r && ph_addr_r == OFF_WDATA) begin
      push_req = 1'b1;
      push_cmd = '{wr: 1'b1, addr: waddr_r, data: hwdata[WORD_W-1:0]};
    end else if (ph_r && ph_wr_r && !ctrl_r[CTRL_RDLOAD]
                 && (ph_addr_r == OFF_ROFS0 || ph_addr_r == OFF_ROFS1)) begin
      push_req = 1'b1;
      push_cmd = '{wr: 1'b0, addr: hwdata[ADDR_W-1:0], data: '0};
    end else if (ph_r && !ph_wr_r && ctrl_r[CTRL_RDLOAD]
                 && ph_addr_r == OFF_RDATA) begin
      push_req = 1'b1;
      push_cmd = '{wr: 1'b0, addr: sel_ofs, data: '0};
    end
  end

  assign stall = push_req && !buf_in_ready;
  assign commit = ph_r && !stall;

  always_comb begin
    rd_mux = '0;
    case (ph_addr_r)
      OFF_CTRL: rd_mux[CTRL_W-1:0] = ctrl_r;
      OFF_STAT: begin
        rd_mux[STAT_BUSY] = (st_r != ST_IDLE) || buf_out_valid;
        rd_mux[STAT_RDV] = rdv_r;
        rd_mux[STAT_FULL] = !buf_in_ready;
      end
      OFF_RDATA: rd_mux[WORD_W-1:0] = rdata_r;
      OFF_ROFS0: rd_mux[ADDR_W-1:0] = rofs_r[0];
      OFF_ROFS1: rd_mux[ADDR_W-1:0] = rofs_r[1];
      OFF_WADDR: rd_mux[ADDR_W-1:0] = waddr_r;
      default: rd_mux = '0;
    endcase
  end

  // Single port for both cores; arbitration sits upstream
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ph_r <= 1'b0;
      ph_wr_r <= 1'b0;
      ph_addr_r <= '0;
      hreadyout_r <= 1'b1;
      hrdata_r <= '0;
    end else if (!ph_r) begin
      if (hsel && htrans[1] && hready) begin
        ph_r <= 1'b1;
        ph_wr_r <= hwrite;
        ph_addr_r <= {haddr[7:2], 2'b00};
        hreadyout_r <= 1'b0;
      end
    end else if (commit) begin
      ph_r <= 1'b0;
      hreadyout_r <= 1'b1;
      hrdata_r <= ph_wr_r ? 32'h00000000 : rd_mux;
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = 1'b0;

  // ------------------------------------------------------------
  // Software registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_r <= CTRL_RESET;
      rofs_r[0] <= '0;
      rofs_r[1] <= '0;
      waddr_r <= '0;
    end else if (commit && ph_wr_r) begin
      case (ph_addr_r)
        OFF_CTRL: ctrl_r <= hwdata[CTRL_W-1:0];
        OFF_ROFS0: rofs_r[0] <= hwdata[ADDR_W-1:0];
        OFF_ROFS1: rofs_r[1] <= hwdata[ADDR_W-1:0];
        OFF_WADDR: waddr_r <= hwdata[ADDR_W-1:0];
        default: ;
      endcase
    end
  end

  // Read-valid: a completing read wins over a same-cycle clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdv_r <= 1'b0;
      rd_irq_r <= 1'b0;
    end else begin
      if (rd_done) begin
        rdv_r <= 1'b1;
      end else if (commit && !ph_wr_r && ph_addr_r == OFF_RDATA) begin
        rdv_r <= 1'b0;
      end
      rd_irq_r <= rd_done ? ctrl_r[CTRL_IE] : (rdv_r && ctrl_r[CTRL_IE]);
    end
  end

  assign rd_irq = rd_irq_r;

  // ------------------------------------------------------------
  // Command buffer and refresh divider
  // ------------------------------------------------------------
  cmd_buffer #(
    .W($bits(cmd_t)),
    .DEPTH(2)
  ) u_buf (
    .clk(clk),
    .reset(reset),
    .in_valid(push_req),
    .in_ready(buf_in_ready),
    .in_data(push_cmd),
    .out_valid(buf_out_valid),
    .out_ready(buf_pop),
    .out_data(buf_out)
  );

  refresh_tick #(
    .BASE(REF_BASE)
  ) u_ref (
    .clk(clk),
    .reset(reset),
    .sel(ctrl_r[CTRL_RDIV +: 3]),
    .tick(ref_tick)
  );

  // Tick wins over the clear taken when refresh starts
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ref_pend_r <= 1'b0;
    end else if (ref_tick && !is_sram) begin
      ref_pend_r <= 1'b1;
    end else if (st_r == ST_IDLE && !is_sram) begin
      ref_pend_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // External cycle engine
  // ------------------------------------------------------------
  // Refresh takes priority over queued words when idle
  assign buf_pop = (st_r == ST_IDLE) && !(ref_pend_r && !is_sram) && buf_out_valid;

  always_comb begin
    if (is_sram) begin
      units = is_w24 ? UNITS_SRAM24 : UNITS_SRAM16;
    end else begin
      units = is_w24 ? UNITS_DRAM24 : UNITS_DRAM16;
    end
  end

  assign ua = cmd_addr_r + ADDR_W'(idx_r);
  assign stb_cyc = STROBE_CYC + STROBE_STEP * 8'(ctrl_r[CTRL_STIM +: 2]);
  assign gap_cyc = is_sram ? RECOVER_CYC : PRECHARGE_CYC;
  assign wr_unit = is_sram ? wsh_r[WORD_W-1 -: AD_W] : {4'h0, wsh_r[WORD_W-1 -: DQ_W]};
  assign rd_done = (st_r == ST_GAP) && (tmr_r == 8'h00) && (idx_r == units) && !cmd_wr_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r <= ST_IDLE;
      tmr_r <= '0;
      idx_r <= '0;
      pins_r <= PINS_IDLE;
    end else if (tmr_r != 8'h00) begin
      tmr_r <= tmr_r - 8'h01;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (ref_pend_r && !is_sram) begin
            pins_r.cas_n <= 1'b0;
            tmr_r <= CAS_RAS_CYC - 8'h01;
            st_r <= ST_RF_CAS;
          end else if (buf_out_valid) begin
            idx_r <= '0;
            st_r <= ST_START;
          end
        end
        ST_START: begin
          if (!is_sram) begin
            pins_r.ma <= ua[ADDR_W-1 -: MA_W];
            pins_r.ras_n <= 1'b0;
            tmr_r <= CAS_RAS_CYC - 8'h01;
            st_r <= ST_ROW;
          end else begin
            // Relative address in two latched phases on the shared lines
            pins_r.cs_n <= 1'b0;
            pins_r.ale <= 1'b1;
            pins_r.ad_oe_n <= 1'b0;
            pins_r.ad_o <= AD_W'(ua[SRAM_A_W-1:AD_W]);
            tmr_r <= CAS_RAS_CYC - 8'h01;
            st_r <= ST_SA_HI;
          end
        end
        ST_ROW: begin
          pins_r.ma <= ua[MA_W-1:0];
          pins_r.cas_n <= 1'b0;
          pins_r.we_n <= !cmd_wr_r;
          pins_r.dq_o <= wr_unit[DQ_W-1:0];
          pins_r.dq_oe_n <= !cmd_wr_r;
          tmr_r <= stb_cyc - 8'h01;
          st_r <= ST_STB;
        end
        ST_SA_HI: begin
          pins_r.ad_o <= ua[AD_W-1:0];
          tmr_r <= CAS_RAS_CYC - 8'h01;
          st_r <= ST_SA_LO;
        end
        ST_SA_LO: begin
          pins_r.ale <= 1'b0;
          pins_r.ad_o <= wr_unit;
          pins_r.ad_oe_n <= !cmd_wr_r;
          pins_r.wr_n <= !cmd_wr_r;
          pins_r.rd_n <= cmd_wr_r;
          tmr_r <= stb_cyc - 8'h01;
          st_r <= ST_STB;
        end
        ST_STB: begin
          pins_r <= PINS_IDLE;
          idx_r <= idx_r + 3'h1;
          tmr_r <= gap_cyc - 8'h01;
          st_r <= ST_GAP;
        end
        ST_GAP: begin
          st_r <= (idx_r == units) ? ST_IDLE : ST_START;
        end
        ST_RF_CAS: begin
          pins_r.ras_n <= 1'b0;
          tmr_r <= RF_HOLD_CYC - 8'h01;
          st_r <= ST_RF_RAS;
        end
        ST_RF_RAS: begin
          pins_r <= PINS_IDLE;
          tmr_r <= PRECHARGE_CYC - 8'h01;
          st_r <= ST_RF_PRE;
        end
        ST_RF_PRE: st_r <= ST_IDLE;
        default: begin
          pins_r <= PINS_IDLE;
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  assign pins = pins_r;

  // Word shift registers: left-aligned out, shifted in at the bottom
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmd_wr_r <= 1'b0;
      cmd_addr_r <= '0;
      wsh_r <= '0;
      rsh_r <= '0;
      rdata_r <= '0;
    end else begin
      if (buf_pop) begin
        cmd_wr_r <= buf_out.wr;
        cmd_addr_r <= buf_out.addr;
        wsh_r <= is_w24 ? buf_out.data : {buf_out.data[15:0], 8'h00};
        rsh_r <= '0;
      end else if (st_r == ST_STB && tmr_r == 8'h00) begin
        if (is_sram) begin
          wsh_r <= wsh_r << AD_W;
          rsh_r <= {rsh_r[WORD_W-AD_W-1:0], ad_i};
        end else begin
          wsh_r <= wsh_r << DQ_W;
          rsh_r <= {rsh_r[WORD_W-DQ_W-1:0], dq_i};
        end
      end
      if (rd_done) begin
        rdata_r <= is_w24 ? rsh_r : {8'h00, rsh_r[15:0]};
      end
    end
  end

endmodule : external_memory_port

//--- sim/external_memory_port_assertions.sv
// Checker for the external memory port: bus answers and pin timing.
// Assumes it is bound to the port and sees only the port's own pins.
`timescale 1ns/100ps
module emp_checker
  import ext_mem_pkg::*;
#(
  parameter int REF_BASE = REF_BASE_CYC
) (
  // Clock and reset
  input logic clk,
  input logic reset,
  // Bus
  input logic hsel,
  input logic [1:0] htrans,
  input logic hready,
  input logic hreadyout,
  input logic hresp,
  // Memory side
  input mem_pins_t pins,
  input logic rd_irq
);
  logic [7:0] ras_hi, cas_lo, stb_lo;
  wire logic stb = !pins.rd_n || !pins.wr_n;

  // Row-strobe gap count saturates so the long idle after reset never wraps to a short gap
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ras_hi <= 8'hFF;
      cas_lo <= 8'h00;
      stb_lo <= 8'h00;
    end else begin
      ras_hi <= !pins.ras_n ? 8'h00 : (ras_hi == 8'hFF ? ras_hi : ras_hi + 8'h01);
      cas_lo <= pins.cas_n ? 8'h00 : cas_lo + 8'h01;
      stb_lo <= !stb ? 8'h00 : stb_lo + 8'h01;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_ready_drop: assert property (hsel && htrans[1] && hready |=> !hreadyout)
    else $error("no wait state after address phase");
  a_refresh_order: assert property (($fell(pins.cas_n) && pins.ras_n) |->
    (pins.ras_n && !pins.cas_n) [*5] ##1 (!pins.ras_n && !pins.cas_n))
    else $error("refresh strobes out of order");
  a_row_precharge: assert property ($fell(pins.ras_n) |-> ras_hi >= PRECHARGE_CYC)
    else $error("row strobe precharge too short");
  a_sram_width: assert property ($fell(stb) |->
    stb_lo inside {8'h0C, 8'h10, 8'h14, 8'h18})
    else $error("sram strobe width wrong");
  a_cas_width: assert property ($rose(pins.cas_n) |->
    cas_lo inside {8'h0C, 8'h10, 8'h14, 8'h18, 8'h21})
    else $error("column strobe width wrong");
  a_mode_apart: assert property (pins.cs_n || (pins.ras_n && pins.cas_n))
    else $error("dram and sram strobes together");
  a_ale_drive: assert property (pins.ale |-> !pins.cs_n && !pins.ad_oe_n)
    else $error("address phase without select or drive");
  a_ale_phase: assert property ($rose(pins.ale) |->
    pins.ale [*8] ##1 pins.ale [*2] ##1 (!pins.ale && stb))
    else $error("sram address phase length wrong");

  c_refresh: cover property ($fell(pins.cas_n) && pins.ras_n);
  c_sram_write: cover property ($fell(pins.wr_n));
  c_irq: cover property ($rose(rd_irq));
endmodule : emp_checker

bind external_memory_port emp_checker #(.REF_BASE(REF_BASE)) i_chk (
  .clk(clk), .reset(reset), .hsel(hsel), .htrans(htrans), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .pins(pins), .rd_irq(rd_irq));

//--- sim/ext_mem_model.sv
// Behavioural external DRAM (nibble wide) and SRAM (byte wide).
// Assumes the port owns all timing; read data valid while strobed.
`timescale 1ns/100ps
module ext_mem_model
  import ext_mem_pkg::*;
(
  // Clock and reset
  input logic clk,
  input logic reset,
  // Pins from the port
  input mem_pins_t pins,
  // Read data to the port
  output logic [DQ_W-1:0] dq_i,
  output logic [AD_W-1:0] ad_i
);
  logic [3:0] dmem [0:262143];
  logic [7:0] smem [0:16383];
  logic [8:0] row_r;
  logic [13:0] sa_r;
  logic [3:0] ale_cnt_r, dq_last_r;
  logic [7:0] ad_last_r;
  wire logic dq_drive = !pins.ras_n && !pins.cas_n && pins.we_n;
  wire logic ad_drive = !pins.cs_n && !pins.rd_n;

  // Released lines show the inverse of the last value, never a stale match
  assign dq_i = dq_drive ? dmem[{row_r, pins.ma}] : ~dq_last_r;
  assign ad_i = ad_drive ? smem[sa_r] : ~ad_last_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      row_r <= 9'h000;
      sa_r <= 14'h0000;
      ale_cnt_r <= 4'h0;
      dq_last_r <= 4'h0;
      ad_last_r <= 8'h00;
    end else begin
      if (!pins.ras_n && pins.cas_n)
        row_r <= pins.ma;
      if (!pins.ras_n && !pins.cas_n && !pins.we_n)
        dmem[{row_r, pins.ma}] <= pins.dq_o;
      if (dq_drive)
        dq_last_r <= dq_i;
      ale_cnt_r <= (pins.ale && !pins.cs_n) ? ale_cnt_r + 4'h1 : 4'h0;
      if (pins.ale && !pins.cs_n && ale_cnt_r < 4'h5)
        sa_r[13:8] <= pins.ad_o[5:0];
      else if (pins.ale && !pins.cs_n)
        sa_r[7:0] <= pins.ad_o;
      if (!pins.cs_n && !pins.wr_n)
        smem[sa_r] <= pins.ad_o;
      if (ad_drive)
        ad_last_r <= ad_i;
    end
  end
endmodule : ext_mem_model

//--- sim/external_memory_port_tb.sv
// Self-checking bench: register access, DRAM and SRAM words, refresh.
// Assumes the port is the only bus slave and the model is its memory.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %s expected %h seen %h", nm, e, g); end end
module external_memory_port_tb
  import ext_mem_pkg::*;
;
  localparam int RB = 64;
  logic clk, reset, hsel, hwrite, hreadyout, hresp, rd_irq;
  logic cas_q = 1'b1;
  logic [31:0] haddr, hwdata, hrdata, rv, w, ctl;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [17:0] a;
  mem_pins_t pins;
  logic [DQ_W-1:0] dq_i;
  logic [AD_W-1:0] ad_i;
  wire logic hready = hreadyout;
  int err_total = 0, checks = 0, cyc = 0, rf_n = 0, rf_last = 0, t1, n0;

  external_memory_port #(.REF_BASE(RB)) i_dut (.clk(clk), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pins(pins),
    .dq_i(dq_i), .ad_i(ad_i), .rd_irq(rd_irq));
  ext_mem_model i_mem (.clk(clk), .reset(reset), .pins(pins), .dq_i(dq_i), .ad_i(ad_i));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Refresh starts: column strobe falls while the row strobe is high
  always @(posedge clk) begin
    cyc <= cyc + 1;
    cas_q <= pins.cas_n;
    if (!pins.cas_n && cas_q && pins.ras_n) begin
      rf_n <= rf_n + 1;
      rf_last <= cyc;
    end
  end

  task automatic bus(input logic wr_en, input logic [7:0] ad, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr_en;
    haddr <= {24'h000000, ad};
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, ad, d, r);
  endtask : wr

  task automatic rd(input logic [7:0] ad, output logic [31:0] r);
    bus(1'b0, ad, 32'h00000000, r);
  endtask : rd

  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do begin
      rd(OFF_STAT, rv);
      n++;
    end while (rv[b] !== v && n < 400);
    `CHK("status flag", v, rv[b])
  endtask : poll

  task final_report;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  // Longest path is the refresh sweep, under 50k cycles
  initial begin
    #400000;
    err_total++;
    final_report;
  end

  initial begin
    reset = 1'b1;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd(OFF_CTRL, rv);
    `CHK("ctrl reset", 32'(CTRL_RESET), rv)
    rd(OFF_STAT, rv);
    `CHK("stat reset", 32'h00000000, rv)
    wr(8'h1C, 32'hFFFFFFFF);
    rd(8'h1C, rv);
    `CHK("unmapped", 32'h00000000, rv)
    rd(OFF_CTRL, rv);
    `CHK("ctrl kept", 32'h00000000, rv)
    $display("test registers done");
    // Base straddles a row boundary so the row/column split shows
    for (int k = 0; k < 2; k++) begin
      a = 18'h201FD;
      w = 32'hFFA5C3E1;
      wr(OFF_CTRL, (32'(k) << CTRL_W24) | (32'h7 << CTRL_RDIV));
      wr(OFF_WADDR, 32'(a));
      wr(OFF_WDATA, w);
      poll(STAT_BUSY, 1'b0);
      for (int i = 0; i < 4 + 2 * k; i++)
        `CHK("dram nibble", w[(3 + 2 * k - i) * 4 +: 4], i_mem.dmem[a + 18'(i)])
      wr(k ? OFF_ROFS1 : OFF_ROFS0, 32'(a));
      poll(STAT_RDV, 1'b1);
      rd(OFF_RDATA, rv);
      `CHK("dram word", k ? {8'h00, w[23:0]} : {16'h0000, w[15:0]}, rv)
      rd(OFF_STAT, rv);
      `CHK("rdv cleared", 1'b0, rv[STAT_RDV])
    end
    $display("test dram done");
    for (int s = 0; s < 4; s++) begin
      a = 18'h000FE + 18'(s * 16);
      w = 32'h00123456 + 32'(s);
      ctl = 32'h00000003 | (32'(s) << CTRL_STIM);
      wr(OFF_CTRL, ctl);
      wr(OFF_WADDR, 32'(a));
      wr(OFF_WDATA, w);
      poll(STAT_BUSY, 1'b0);
      for (int i = 0; i < 3; i++)
        `CHK("sram byte", w[(2 - i) * 8 +: 8], i_mem.smem[a[13:0] + 14'(i)])
      // Odd passes load through the second offset; the first still holds a stale base
      wr(OFF_CTRL, ctl | (32'h1 << CTRL_RDLOAD) | (32'h1 << CTRL_IE)
         | (32'(s % 2) << CTRL_OFSSEL));
      wr((s % 2) ? OFF_ROFS1 : OFF_ROFS0, 32'(a));
      rd(OFF_RDATA, rv);
      poll(STAT_RDV, 1'b1);
      `CHK("irq raised", 1'b1, rd_irq)
      rd(OFF_RDATA, rv);
      `CHK("sram word", {8'h00, w[23:0]}, rv)
      poll(STAT_RDV, 1'b1);
      wr(OFF_CTRL, ctl);
      rd(OFF_STAT, rv);
      `CHK("irq masked", 1'b0, rd_irq)
    end
    $display("test sram done");
    // Skip a refresh that may still come from the old setting, then time one gap
    for (int r = 0; r < 8; r++) begin
      wr(OFF_CTRL, 32'(r) << CTRL_RDIV);
      n0 = rf_n;
      while (rf_n < n0 + 2) @(posedge clk);
      t1 = rf_last;
      while (rf_n < n0 + 3) @(posedge clk);
      `CHK("refresh gap", RB << r, rf_last - t1)
    end
    $display("test refresh done");
    final_report;
  end
endmodule : external_memory_port_tb
